// ---- pkg/usb_frame_pkg.sv ----
// constants and carrier types for the usb frame index and periodic gate
package usb_frame_pkg;

  // apb register byte addresses
  localparam logic [7:0] CMD_ADDR   = 8'h00;
  localparam logic [7:0] STS_ADDR   = 8'h04;
  localparam logic [7:0] INDEX_ADDR = 8'h0c;
  localparam logic [7:0] BASE_ADDR  = 8'h14;
  localparam logic [7:0] SOF_FRAME_SHADOW_ADDR  = 8'h18;

  // host_command_reg fields
  localparam int RUN_BIT = 0;
  localparam int PSE_BIT = 4;
  // host_status_reg fields
  localparam int HALT_BIT = 12;
  localparam int PS_BIT   = 14;

  // field widths and positions
  localparam int INDEX_W   = 14;
  localparam int UFRAME_W  = 3;
  localparam int FRAME_W   = 11;
  localparam int BASE_LSB  = 12;
  localparam int SLOT_MSB  = 12;

  // reset values
  localparam logic [13:0] INDEX_RST = 14'h0000;
  localparam logic [10:0] SOF_FRAME_SHADOW_RST  = 11'h000;
  localparam logic [19:0] BASE_RST  = 20'h00000;
  localparam logic [2:0]  UFRAME_ZERO = 3'h0;

  // micro-frame timing
  localparam int UFRAME_NS  = 125000;
  localparam int CLK_NS     = 25;
  localparam int UFRAME_CYC = UFRAME_NS / CLK_NS;
  localparam int TMR_W      = 16;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_FETCH,
    PH_PERIODIC,
    PH_ASYNC
  } phase_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

endpackage

// ---- hw/usb_frame_gate.sv ----
// frame list index, sof shadow and periodic schedule gate behind an apb slave
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps

module usb_frame_gate #(
  parameter int unsigned UFRAME_CYCLES = usb_frame_pkg::UFRAME_CYC
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire usb_frame_pkg::apb_req_s apbReq,
  output usb_frame_pkg::apb_rsp_s      apbRsp,
  input  wire logic                    fetchAck,
  input  wire logic                    periodicEnd,
  output logic                         fetchReq,
  output logic [31:0]                  fetchAddr,
  output logic                         periodicActive,
  output logic                         asyncActive,
  output logic                         sofPulse,
  output logic [10:0]                  sofFrame,
  output logic [2:0]                   uframeNum
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [usb_frame_pkg::TMR_W-1:0]    tmr_ff;
  logic                               run_ff;
  logic                               pse_ff;
  logic                               ps_ff;
  logic [usb_frame_pkg::INDEX_W-1:0]  index_ff;
  logic [usb_frame_pkg::FRAME_W-1:0]  shadow_ff;
  logic [19:0]                        base_ff;
  usb_frame_pkg::phase_e              phase_ff;
  logic                               fetchReq_ff;
  logic [31:0]                        fetchAddr_ff;
  logic                               sofPulse_ff;
  logic [10:0]                        sofFrame_ff;
  logic                               pready_ff;
  logic                               pslverr_ff;
  logic [31:0]                        prdata_ff;

  logic                               tick;
  logic                               access;
  logic                               wrEn;
  logic                               wrCmd;
  logic                               wrIndex;
  logic                               wrBase;
  logic                               hit;
  logic [31:0]                        rdMux;
  logic [usb_frame_pkg::INDEX_W-1:0]  nxt_index;
  logic [usb_frame_pkg::FRAME_W-1:0]  nxt_shadow;
  logic                               nxt_ps;
  logic [usb_frame_pkg::FRAME_W-1:0]  wrShadow;
  logic [7:0]                         addr;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign addr    = apbReq.paddr[7:0];
  assign access  = apbReq.psel & apbReq.penable;
  assign wrEn    = access & apbReq.pwrite & pready_ff;
  assign wrCmd   = wrEn & (addr == usb_frame_pkg::CMD_ADDR);
  assign wrIndex = wrEn & (addr == usb_frame_pkg::INDEX_ADDR);
  assign wrBase  = wrEn & (addr == usb_frame_pkg::BASE_ADDR);

  assign hit = (apbReq.paddr[31:8] == 24'h000000) &
               ((addr == usb_frame_pkg::CMD_ADDR) |
                (addr == usb_frame_pkg::STS_ADDR) |
                (addr == usb_frame_pkg::INDEX_ADDR) |
                (addr == usb_frame_pkg::BASE_ADDR) |
                (addr == usb_frame_pkg::SOF_FRAME_SHADOW_ADDR));

  always_comb begin
    rdMux = 32'h00000000;
    unique case (addr)
      usb_frame_pkg::CMD_ADDR: begin
        rdMux[usb_frame_pkg::RUN_BIT] = run_ff;
        rdMux[usb_frame_pkg::PSE_BIT] = pse_ff;
      end
      usb_frame_pkg::STS_ADDR: begin
        rdMux[usb_frame_pkg::HALT_BIT] = ~run_ff;
        rdMux[usb_frame_pkg::PS_BIT] = ps_ff;
      end
      usb_frame_pkg::INDEX_ADDR: begin
        rdMux[usb_frame_pkg::INDEX_W-1:0] = index_ff;
      end
      usb_frame_pkg::BASE_ADDR: begin
        rdMux[31:usb_frame_pkg::BASE_LSB] = base_ff;
      end
      usb_frame_pkg::SOF_FRAME_SHADOW_ADDR: begin
        rdMux[usb_frame_pkg::FRAME_W-1:0] = shadow_ff;
      end
      default: begin
        rdMux = 32'h00000000;
      end
    endcase
    if (!hit) begin
      rdMux = 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, then pready

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= access & ~pready_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (access & ~pready_ff) begin
      prdata_ff  <= apbReq.pwrite ? 32'h00000000 : rdMux;
      pslverr_ff <= ~hit;
    end else begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
  end

  assign apbRsp.prdata  = prdata_ff;
  assign apbRsp.pready  = pready_ff;
  assign apbRsp.pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // command and base registers

  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_ff <= 1'b0;
      pse_ff <= 1'b0;
    end else if (wrCmd) begin
      run_ff <= apbReq.pwdata[usb_frame_pkg::RUN_BIT];
      pse_ff <= apbReq.pwdata[usb_frame_pkg::PSE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      base_ff <= usb_frame_pkg::BASE_RST;
    end else if (wrBase) begin
      base_ff <= apbReq.pwdata[31:usb_frame_pkg::BASE_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // micro-frame timer

  // one tick per micro-frame while running
  // an index write in the last timer cycle wins and restarts the count,
  // so no sof goes out with a half-updated index and shadow
  assign tick = run_ff & ~wrIndex &
    (tmr_ff == usb_frame_pkg::TMR_W'(UFRAME_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tmr_ff <= '0;
    end else if (!run_ff || tick || wrIndex) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= tmr_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame list index and sof shadow

  // carry out of micro field steps frame field
  assign nxt_index = index_ff + 14'h0001;

  // shadow steps on micro 0 to 1
  assign nxt_shadow = (index_ff[2:0] == usb_frame_pkg::UFRAME_ZERO) ?
                      shadow_ff + 11'h001 : shadow_ff;

  // a written index gets a shadow one micro-frame behind
  assign wrShadow = (apbReq.pwdata[2:0] == usb_frame_pkg::UFRAME_ZERO) ?
                    apbReq.pwdata[13:3] - 11'h001 : apbReq.pwdata[13:3];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      index_ff <= usb_frame_pkg::INDEX_RST;
    end else if (wrIndex) begin
      index_ff <= apbReq.pwdata[usb_frame_pkg::INDEX_W-1:0];
    end else if (tick) begin
      index_ff <= nxt_index;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shadow_ff <= usb_frame_pkg::SOF_FRAME_SHADOW_RST;
    end else if (wrIndex) begin
      shadow_ff <= wrShadow;
    end else if (tick) begin
      shadow_ff <= nxt_shadow;
    end
  end

  assign uframeNum = index_ff[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // sof token output

  // same shadow value for eight micro-frames
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sofPulse_ff <= 1'b0;
      sofFrame_ff <= usb_frame_pkg::SOF_FRAME_SHADOW_RST;
    end else begin
      sofPulse_ff <= tick;
      if (tick) begin
        sofFrame_ff <= nxt_shadow;
      end
    end
  end

  assign sofPulse = sofPulse_ff;
  assign sofFrame = sofFrame_ff;

  ////////////////////////////////////////////////////////////////////////////
  // periodic schedule status

  assign nxt_ps = (tick && nxt_index[2:0] == usb_frame_pkg::UFRAME_ZERO) ?
                  pse_ff : ps_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ps_ff <= 1'b0;
    end else begin
      ps_ff <= nxt_ps;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per micro-frame phase sequencing

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_ff <= usb_frame_pkg::PH_IDLE;
    end else if (!run_ff) begin
      phase_ff <= usb_frame_pkg::PH_IDLE;
    end else if (tick) begin
      // inactive schedule goes straight to async
      phase_ff <= nxt_ps ? usb_frame_pkg::PH_FETCH : usb_frame_pkg::PH_ASYNC;
    end else begin
      unique case (phase_ff)
        usb_frame_pkg::PH_IDLE: begin
          phase_ff <= usb_frame_pkg::PH_IDLE;
        end
        usb_frame_pkg::PH_FETCH: begin
          if (fetchAck) begin
            phase_ff <= usb_frame_pkg::PH_PERIODIC;
          end
        end
        usb_frame_pkg::PH_PERIODIC: begin
          if (periodicEnd) begin
            phase_ff <= usb_frame_pkg::PH_ASYNC;
          end
        end
        usb_frame_pkg::PH_ASYNC: begin
          phase_ff <= usb_frame_pkg::PH_ASYNC;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // periodic frame list fetch

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fetchReq_ff  <= 1'b0;
      fetchAddr_ff <= 32'h00000000;
    end else if (run_ff && tick && nxt_ps) begin
      fetchReq_ff <= 1'b1;
      fetchAddr_ff <= {base_ff,
                       (wrIndex ? apbReq.pwdata[usb_frame_pkg::SLOT_MSB:3]
                                : nxt_index[usb_frame_pkg::SLOT_MSB:3]),
                       2'b00};
    end else if (!run_ff || fetchAck || tick) begin
      fetchReq_ff <= 1'b0;
    end
  end

  assign fetchReq  = fetchReq_ff;
  assign fetchAddr = fetchAddr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // phase outputs

  logic periodicActive_ff;
  logic asyncActive_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      periodicActive_ff <= 1'b0;
      asyncActive_ff    <= 1'b0;
    end else begin
      periodicActive_ff <= run_ff & ~tick & ~periodicEnd &
                           (phase_ff == usb_frame_pkg::PH_PERIODIC |
                            (phase_ff == usb_frame_pkg::PH_FETCH & fetchAck));
      asyncActive_ff    <= run_ff & ~tick &
                           (phase_ff == usb_frame_pkg::PH_ASYNC |
                            (phase_ff == usb_frame_pkg::PH_PERIODIC & periodicEnd));
    end
  end

  assign periodicActive = periodicActive_ff;
  assign asyncActive    = asyncActive_ff;

endmodule

// ---- sim/usb_frame_gate_properties.sv ----
// port assertions for the frame gate
`timescale 1ns/1ps
module usb_frame_gate_properties #(
  parameter int unsigned UFRAME_CYCLES = usb_frame_pkg::UFRAME_CYC
) (
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire usb_frame_pkg::apb_req_s apbReq,
  input wire usb_frame_pkg::apb_rsp_s apbRsp,
  input wire logic                    fetchAck,
  input wire logic                    periodicEnd,
  input wire logic                    fetchReq,
  input wire logic [31:0]             fetchAddr,
  input wire logic                    periodicActive,
  input wire logic                    asyncActive,
  input wire logic                    sofPulse,
  input wire logic [10:0]             sofFrame,
  input wire logic [2:0]              uframeNum
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic        have_ff;
  logic        hadFetch_ff;
  logic [10:0] lastSof_ff;
  logic [31:0] lastAddr_ff;
  ////////////////////////////////////////////////////////////
  // last sof values, forgotten after any register write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      have_ff     <= 1'b0;
      hadFetch_ff <= 1'b0;
      lastSof_ff  <= 11'h000;
      lastAddr_ff <= 32'h0;
    end else begin
      if (sofPulse) begin
        lastSof_ff  <= sofFrame;
        lastAddr_ff <= fetchAddr;
        hadFetch_ff <= fetchReq;
      end
      if (apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready) have_ff <= 1'b0;
      else if (sofPulse) have_ff <= 1'b1;
    end
  end
  sequence s_ackTaken;
    fetchReq && fetchAck;
  endsequence
  sequence s_walkOn;
    !fetchReq && periodicActive;
  endsequence
  a_uframe_step: assert property (sofPulse |-> uframeNum == 3'($past(uframeNum) + 3'h1))
    else $error("micro-frame did not step");
  a_sof_steady: assert property (sofPulse && have_ff && uframeNum != 3'h1 |->
    sofFrame == lastSof_ff) else $error("sof number changed");
  a_sof_step: assert property (sofPulse && have_ff && uframeNum == 3'h1 |->
    sofFrame == 11'(lastSof_ff + 11'h1)) else $error("sof number did not step");
  a_fetch_start: assert property ($rose(fetchReq) |-> sofPulse)
    else $error("fetch outside micro-frame start");
  a_ack_phase: assert property (s_ackTaken |=> s_walkOn)
    else $error("no periodic phase after ack");
  a_end_async: assert property (periodicActive && periodicEnd |=> !periodicActive && asyncActive)
    else $error("no async phase after list end");
  a_idle_async: assert property (sofPulse && !fetchReq |=> asyncActive && !periodicActive)
    else $error("inactive schedule did not go to async");
  a_gate_zero: assert property (sofPulse && fetchReq != hadFetch_ff |-> uframeNum == 3'h0)
    else $error("gate changed off micro-frame zero");
  a_slot_same: assert property (sofPulse && have_ff && fetchReq && hadFetch_ff |->
    fetchAddr == {lastAddr_ff[31:12], 10'(lastAddr_ff[11:2] + 10'(uframeNum == 3'h0)), 2'h0})
    else $error("frame list slot wrong");
endmodule
bind usb_frame_gate usb_frame_gate_properties #(.UFRAME_CYCLES(UFRAME_CYCLES)) u_props (
  .core_clk, .rst, .apbReq, .apbRsp, .fetchAck, .periodicEnd, .fetchReq, .fetchAddr,
  .periodicActive, .asyncActive, .sofPulse, .sofFrame, .uframeNum);

// ---- sim/fetch_partner.sv ----
// frame list memory model answering fetches
`timescale 1ns/1ps
module fetch_partner (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       fetchReq,
  input  wire logic [2:0] lat,
  output logic            fetchAck,
  output logic            periodicEnd
);
  logic [1:0] st_ff;
  logic [2:0] cnt_ff;
  ////////////////////////////////////////////////////////////
  // ack after lat cycles, list end mark after lat more
  // model list holds no split work items
  // one period-one entry, then the list end mark
  always_ff @(posedge core_clk) begin
    fetchAck    <= 1'b0;
    periodicEnd <= 1'b0;
    if (rst) begin
      st_ff  <= 2'h0;
      cnt_ff <= 3'h0;
    end else if (st_ff == 2'h0) begin
      if (fetchReq) st_ff <= 2'h1;
      cnt_ff <= lat;
    end else if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
    end else begin
      fetchAck    <= (st_ff == 2'h1);
      periodicEnd <= (st_ff == 2'h2);
      st_ff       <= (st_ff == 2'h1) ? 2'h2 : 2'h0;
      cnt_ff      <= lat;
    end
  end
endmodule

// ---- sim/usb_frame_gate_tb.sv ----
// self-checking bench for the frame gate
`timescale 1ns/1ps
module usb_frame_gate_tb;
  logic                    core_clk = 1'b0;
  logic                    rst = 1'b1;
  usb_frame_pkg::apb_req_s apbReq = '0;
  usb_frame_pkg::apb_rsp_s apbRsp;
  logic                    fetchAck, periodicEnd, fetchReq, sofPulse;
  logic                    periodicActive, asyncActive, err, periodic_sched_enable, ps;
  logic [31:0]             fetchAddr, rd, base;
  logic [10:0]             sofFrame;
  logic [13:0]             idx;
  logic [2:0]              uframeNum;
  logic [2:0]              lat = 3'h0;
  int                      badCount = 0;
  int                      cmpCount = 0;
  int                      seed = 82136;

  always #12.5 core_clk = ~core_clk;

  usb_frame_gate #(.UFRAME_CYCLES(20)) i_dut (.core_clk, .rst, .apbReq, .apbRsp, .fetchAck,
    .periodicEnd, .fetchReq, .fetchAddr, .periodicActive, .asyncActive, .sofPulse,
    .sofFrame, .uframeNum);
  fetch_partner i_mem (.core_clk, .rst, .fetchReq, .lat, .fetchAck, .periodicEnd);
  ////////////////////////////////////////////////////////////
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    apbReq <= '{1'b1, 1'b0, w, {24'h0, a}, d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 50);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (n >= 50) begin
      badCount++;
      printVerdict();
    end
  endtask

  task automatic waitSof();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sofPulse !== 1'b1 && n < 100);
    if (n >= 100) begin
      badCount++;
      printVerdict();
    end
  endtask

  function automatic logic [10:0] shadowOf(input logic [13:0] n);
    return (n[2:0] == 3'h0) ? 11'(n[13:3] - 11'h1) : n[13:3];
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, usb_frame_pkg::STS_ADDR, 32'h0);
    chk("status", 32'h1 << usb_frame_pkg::HALT_BIT, rd);
    apb(1'b0, 8'h08, 32'h0);
    chk("pslverr", 32'h1, 32'(err));
    for (int i = 0; i < 6; i++) begin
      idx = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3fff : 14'($random(seed));
      apb(1'b1, usb_frame_pkg::INDEX_ADDR, 32'(idx));
      apb(1'b0, usb_frame_pkg::INDEX_ADDR, 32'h0);
      chk("index", 32'(idx), rd);
      apb(1'b0, usb_frame_pkg::SOF_FRAME_SHADOW_ADDR, 32'h0);
      chk("shadow", 32'(shadowOf(idx)), rd);
    end
    base = 32'($random(seed)) & 32'hfffff000;
    apb(1'b1, usb_frame_pkg::BASE_ADDR, base);
    idx = 14'h3ffd;
    apb(1'b1, usb_frame_pkg::INDEX_ADDR, 32'(idx));
    periodic_sched_enable = 1'b0;
    ps = 1'b0;
    apb(1'b1, usb_frame_pkg::CMD_ADDR, 32'h1);
    for (int k = 0; k < 40; k++) begin
      waitSof();
      idx = idx + 14'h1;
      if (idx[2:0] == 3'h0) ps = periodic_sched_enable;
      chk("uframe", 32'(idx[2:0]), 32'(uframeNum));
      chk("sof", 32'(shadowOf(idx)), 32'(sofFrame));
      chk("fetch", 32'(ps), 32'(fetchReq));
      if (ps) chk("addr", {base[31:12], idx[12:3], 2'h0}, fetchAddr);
      lat <= 3'($random(seed));
      if (k == 3 || k == 21) begin
        periodic_sched_enable = ~periodic_sched_enable;
        apb(1'b1, usb_frame_pkg::CMD_ADDR, {27'h0, periodic_sched_enable, 4'h1});
      end
      apb(1'b0, usb_frame_pkg::STS_ADDR, 32'h0);
      chk("status", 32'(ps) << usb_frame_pkg::PS_BIT, rd);
    end
    apb(1'b1, usb_frame_pkg::CMD_ADDR, 32'h0);
    repeat (60) @(posedge core_clk);
    apb(1'b0, usb_frame_pkg::INDEX_ADDR, 32'h0);
    chk("held", 32'(idx), rd);
    printVerdict();
  end
endmodule
